// >>> src/crossbar_defines.svh
// Register offsets, field positions, reset values and behaviour overview of the port crossbar
`ifndef CROSSBAR_DEFINES_SVH
`define CROSSBAR_DEFINES_SVH
// Overview of operation
// - Two-wire bus enable places data and clock pins together, never one alone.
// - Serial transmit, when enabled, always sits on pin 4.
// - Serial receive, when enabled, always sits on pin 5.
// - Serial transmit and receive are enabled independently.
// - Leftover pins stay general purpose; unskipped ones all lie above the priority-placed ones.
// - Analog pin loses pull-up, output driver and digital receiver.
// - Input type bit one means digital, zero means analog.
// - All pins are digital inputs after reset.
// - Drive type bit picks open-drain or push-pull, also for peripherals other than the two-wire pins.
// - Two-wire data and clock pins are always open-drain.
// - With pull-up disable clear, open-drain pins get the weak pull-up.
// - Pull-up disable bit never affects push-pull pins.
// - Pull-up is off while an open-drain pin drives low.
// - Writing one to the crossbar enable bit starts routing.
// - Crossbar off turns every pin driver off; digital pins stay inputs, analog pins stay analog.
// - Counter field routes none, output 0, outputs 0-1, or outputs 0-2.
// - Routing bit 5 places the asynchronous comparator output.
// - Routing bit 4 places the synchronous comparator output.
// - Routing bit 3 places the inverted system clock output.
// - Each enabled signal except serial transmit and receive takes the lowest free pin, in fixed priority order.
// - Skipped pins count as taken; the next signal goes further up.

`define ADDR_SKIP_MASK 8'hE1
`define ADDR_PERIPH_SEL 8'hE2
`define ADDR_GLOBAL_CTRL 8'hE3
`define ADDR_PIN_CLAIMED 8'hE4
`define ADDR_INPUT_TYPE 8'hF1
`define ADDR_DRIVE_TYPE 8'hF4

`define RST_SKIP_MASK 8'h00
`define RST_PERIPH_SEL 8'h00
`define RST_GLOBAL_CTRL 8'h00
`define RST_INPUT_TYPE 8'hFF
`define RST_DRIVE_TYPE 8'h00

`define SKIP_WRITABLE 8'h7F
`define GLOBAL_WRITABLE 8'hC0

`define BIT_TX_ROUTE 0
`define BIT_RX_ROUTE 1
`define BIT_TWOWIRE_ROUTE 2
`define BIT_CLK_ROUTE 3
`define BIT_CMP_SYNC_ROUTE 4
`define BIT_CMP_ASYNC_ROUTE 5
`define BIT_CEX_HI 7
`define BIT_CEX_LO 6
`define BIT_PULLUP_DISABLE 7
`define BIT_CROSSBAR_ON 6

`define TX_PIN 4
`define RX_PIN 5
`endif

// >>> src/crossbar_pkg.sv
// Types shared by the port crossbar files
package crossbar_pkg;
  // Code value is also the placement priority, lowest first
  typedef enum logic [3:0] {
    FN_GPIO = 4'h0,
    FN_TX = 4'h1,
    FN_RX = 4'h2,
    FN_SDA = 4'h3,
    FN_SCL = 4'h4,
    FN_CMP_SYNC = 4'h5,
    FN_CMP_ASYNC = 4'h6,
    FN_CLK_INV = 4'h7,
    FN_COUNTER_MODULE_OUT0 = 4'h8,
    FN_CEX1 = 4'h9,
    FN_CEX2 = 4'hA
  } pin_func_t;

  // Peripheral levels heading for the pins; bus lines low means pull low
  typedef struct packed {
    logic tx;
    logic sda;
    logic scl;
    logic cmp_sync;
    logic cmp_async;
    logic clk_inv;
    logic [2:0] cex;
  } periph_out_t;

  // Pin levels handed back to the peripherals
  typedef struct packed {
    logic rx;
    logic sda;
    logic scl;
  } periph_in_t;
endpackage

// >>> src/input_sync.sv
// Two-stage synchroniser for asynchronous pin levels
`timescale 1ns/1ps
module input_sync #(
  parameter int WIDTH = 8
)
(
  input wire logic mclk,
  input wire logic rst_b,
  input wire logic [WIDTH-1:0] d,
  output logic [WIDTH-1:0] q
);
  logic [WIDTH-1:0] meta_q;

  // First stage feeds only the second; idle pins read high
  always_ff @(posedge mclk)
  begin
    if (!rst_b)
    begin
      meta_q <= '1;
      q <= '1;
    end
    else
    begin
      meta_q <= d;
      q <= meta_q;
    end
  end
endmodule

// >>> src/port_crossbar_pin_assign.sv
// Priority crossbar placing peripheral signals on an 8-pin port
`timescale 1ns/1ps
`include "crossbar_defines.svh"
module port_crossbar_pin_assign
(
  input wire logic mclk,
  input wire logic rst_b,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [7:0] reg_rdata,
  input wire crossbar_pkg::periph_out_t periph_out,
  output crossbar_pkg::periph_in_t periph_in,
  input wire logic [7:0] gpio_latch,
  input wire logic [7:0] pin_in,
  output logic [7:0] pin_out,
  output logic [7:0] pin_oe,
  output logic [7:0] pin_pullup_en,
  output logic [7:0] pin_rx_en,
  output logic [7:0] pin_level
);
  localparam int PINS = 8;

  logic [7:0] skip_q;
  logic [7:0] sel_q;
  logic [7:0] glob_q;
  logic [7:0] in_type_q;
  logic [7:0] drv_type_q;
  logic [7:0] rdata_d;
  logic [7:0] rdata_q;
  logic [7:0] pin_sync;
  logic [7:0] claimed_d;
  logic [7:0] placed_d;
  logic [7:0] assigned_d;
  logic [10:0] req;
  logic found;
  logic xbar_on;
  crossbar_pkg::pin_func_t func_d [PINS];
  logic [7:0] is_sda_v;
  logic [7:0] is_scl_v;
  crossbar_pkg::periph_in_t periph_in_d;
  crossbar_pkg::periph_in_t periph_in_q;

  assign xbar_on = glob_q[`BIT_CROSSBAR_ON];

  // Pin levels cross into the clock domain before any logic sees them
  input_sync #(
    .WIDTH(PINS)
  ) u_sync (
    .mclk(mclk),
    .rst_b(rst_b),
    .d(pin_in),
    .q(pin_sync)
  );

  // Configuration registers; writes land at the next edge
  always_ff @(posedge mclk)
  begin
    if (!rst_b)
    begin
      skip_q <= `RST_SKIP_MASK;
      sel_q <= `RST_PERIPH_SEL;
      glob_q <= `RST_GLOBAL_CTRL;
      in_type_q <= `RST_INPUT_TYPE;
      drv_type_q <= `RST_DRIVE_TYPE;
    end
    else if (reg_wr)
    begin
      unique case (reg_addr)
        `ADDR_SKIP_MASK: skip_q <= reg_wdata & `SKIP_WRITABLE;
        `ADDR_PERIPH_SEL: sel_q <= reg_wdata;
        `ADDR_GLOBAL_CTRL: glob_q <= reg_wdata & `GLOBAL_WRITABLE;
        `ADDR_INPUT_TYPE: in_type_q <= reg_wdata;
        `ADDR_DRIVE_TYPE: drv_type_q <= reg_wdata;
        default: ;
      endcase
    end
  end

  // Read mux; unmapped addresses answer zero
  always_comb
  begin
    unique case (reg_addr)
      `ADDR_SKIP_MASK: rdata_d = skip_q;
      `ADDR_PERIPH_SEL: rdata_d = sel_q;
      `ADDR_GLOBAL_CTRL: rdata_d = glob_q;
      `ADDR_PIN_CLAIMED: rdata_d = assigned_d;
      `ADDR_INPUT_TYPE: rdata_d = in_type_q;
      `ADDR_DRIVE_TYPE: rdata_d = drv_type_q;
      default: rdata_d = 8'h00;
    endcase
  end

  // Read data stand only in the cycle after the strobe
  always_ff @(posedge mclk)
  begin
    if (!rst_b)
      rdata_q <= 8'h00;
    else if (reg_rd)
      rdata_q <= rdata_d;
    else
      rdata_q <= 8'h00;
  end

  assign reg_rdata = rdata_q;

  // Priority decoder, rebuilt every cycle from the registers
  always_comb
  begin
    claimed_d = skip_q & `SKIP_WRITABLE;
    placed_d = 8'h00;
    found = 1'b0;
    for (int p = 0; p < PINS; p++)
      func_d[p] = crossbar_pkg::FN_GPIO;
    req = '0;
    req[crossbar_pkg::FN_SDA] = sel_q[`BIT_TWOWIRE_ROUTE];
    req[crossbar_pkg::FN_SCL] = sel_q[`BIT_TWOWIRE_ROUTE];
    req[crossbar_pkg::FN_CMP_SYNC] = sel_q[`BIT_CMP_SYNC_ROUTE];
    req[crossbar_pkg::FN_CMP_ASYNC] = sel_q[`BIT_CMP_ASYNC_ROUTE];
    req[crossbar_pkg::FN_CLK_INV] = sel_q[`BIT_CLK_ROUTE];
    req[crossbar_pkg::FN_COUNTER_MODULE_OUT0] = |sel_q[`BIT_CEX_HI:`BIT_CEX_LO];
    req[crossbar_pkg::FN_CEX1] = sel_q[`BIT_CEX_HI];
    req[crossbar_pkg::FN_CEX2] = &sel_q[`BIT_CEX_HI:`BIT_CEX_LO];
    // Fixed serial pins ignore both skip mask and priority
    if (sel_q[`BIT_TX_ROUTE])
    begin
      claimed_d[`TX_PIN] = 1'b1;
      func_d[`TX_PIN] = crossbar_pkg::FN_TX;
    end
    if (sel_q[`BIT_RX_ROUTE])
    begin
      claimed_d[`RX_PIN] = 1'b1;
      func_d[`RX_PIN] = crossbar_pkg::FN_RX;
    end
    // Bus pins go as a pair; with one free pin neither is placed
    if ($countones(~claimed_d) < 2)
    begin
      req[crossbar_pkg::FN_SDA] = 1'b0;
      req[crossbar_pkg::FN_SCL] = 1'b0;
    end
    // Enum order is the priority order
    for (int s = crossbar_pkg::FN_SDA; s <= crossbar_pkg::FN_CEX2; s++)
    begin
      found = 1'b0;
      for (int p = 0; p < PINS; p++)
      begin
        if (req[s] && !found && !claimed_d[p])
        begin
          claimed_d[p] = 1'b1;
          placed_d[p] = 1'b1;
          func_d[p] = crossbar_pkg::pin_func_t'(4'(s));
          found = 1'b1;
        end
      end
    end
  end

  // Pins holding a peripheral signal, shown to software
  always_comb
  begin
    assigned_d = placed_d;
    assigned_d[`TX_PIN] = placed_d[`TX_PIN] | sel_q[`BIT_TX_ROUTE];
    assigned_d[`RX_PIN] = placed_d[`RX_PIN] | sel_q[`BIT_RX_ROUTE];
  end

  // Per-pin cell: value pick, drive mode, pull-up and receiver
  for (genvar p = 0; p < PINS; p++)
  begin : g_pin
    logic val;
    logic is_smb;
    logic pp;
    logic drive;
    logic oe_d;

    always_comb
    begin
      unique case (func_d[p])
        crossbar_pkg::FN_TX: val = periph_out.tx;
        crossbar_pkg::FN_RX: val = 1'b1;
        crossbar_pkg::FN_SDA: val = periph_out.sda;
        crossbar_pkg::FN_SCL: val = periph_out.scl;
        crossbar_pkg::FN_CMP_SYNC: val = periph_out.cmp_sync;
        crossbar_pkg::FN_CMP_ASYNC: val = periph_out.cmp_async;
        crossbar_pkg::FN_CLK_INV: val = periph_out.clk_inv;
        crossbar_pkg::FN_COUNTER_MODULE_OUT0: val = periph_out.cex[0];
        crossbar_pkg::FN_CEX1: val = periph_out.cex[1];
        crossbar_pkg::FN_CEX2: val = periph_out.cex[2];
        default: val = gpio_latch[p];
      endcase
    end

    assign is_smb = (func_d[p] == crossbar_pkg::FN_SDA) || (func_d[p] == crossbar_pkg::FN_SCL);
    assign pp = drv_type_q[p] && !is_smb;
    // Receive pin is input only; analog pins never drive
    assign drive = xbar_on && in_type_q[p] && (func_d[p] != crossbar_pkg::FN_RX);
    assign oe_d = drive && (pp || !val);
    assign is_sda_v[p] = xbar_on && in_type_q[p] && (func_d[p] == crossbar_pkg::FN_SDA);
    assign is_scl_v[p] = xbar_on && in_type_q[p] && (func_d[p] == crossbar_pkg::FN_SCL);

    // Registered pad controls; reset leaves a pulled-up digital input
    always_ff @(posedge mclk)
    begin
      if (!rst_b)
      begin
        pin_out[p] <= 1'b0;
        pin_oe[p] <= 1'b0;
        pin_pullup_en[p] <= 1'b1;
        pin_rx_en[p] <= 1'b1;
        pin_level[p] <= 1'b1;
      end
      else
      begin
        pin_out[p] <= oe_d && val;
        pin_oe[p] <= oe_d;
        // Pull-up only on digital open-drain pins not pulling low
        pin_pullup_en[p] <= in_type_q[p] && !pp && !glob_q[`BIT_PULLUP_DISABLE] && !oe_d;
        pin_rx_en[p] <= in_type_q[p];
        pin_level[p] <= in_type_q[p] ? pin_sync[p] : 1'b1;
      end
    end

    analog_off_a: assert property (@(posedge mclk) disable iff (!rst_b)
      !in_type_q[p] |=> !pin_oe[p] && !pin_pullup_en[p] && !pin_rx_en[p])
      else $error("analog pin still has digital parts on");

    smb_od_a: assert property (@(posedge mclk) disable iff (!rst_b)
      is_smb && drv_type_q[p] && val |=> !pin_oe[p])
      else $error("bus pin driven high");

    pull_rule_a: assert property (@(posedge mclk) disable iff (!rst_b)
      in_type_q[p] && !drv_type_q[p] && !is_smb && !glob_q[`BIT_PULLUP_DISABLE] && !oe_d
      |=> pin_pullup_en[p])
      else $error("open-drain pin lost its pull-up");

    pull_pp_a: assert property (@(posedge mclk) disable iff (!rst_b)
      pp |=> !pin_pullup_en[p])
      else $error("push-pull pin has a pull-up");

    pull_low_a: assert property (@(posedge mclk) disable iff (!rst_b)
      pin_oe[p] && !pin_out[p] |-> !pin_pullup_en[p])
      else $error("pull-up on while pulling low");

    skip_hold_a: assert property (@(posedge mclk) disable iff (!rst_b)
      skip_q[p] && (p != `TX_PIN) && (p != `RX_PIN) |-> func_d[p] == crossbar_pkg::FN_GPIO)
      else $error("skipped pin got a signal");
  end

  // Bus lines read back from their pins, idle high when unrouted
  always_comb
  begin
    periph_in_d.sda = &(~is_sda_v | pin_sync);
    periph_in_d.scl = &(~is_scl_v | pin_sync);
    if (xbar_on && sel_q[`BIT_RX_ROUTE] && in_type_q[`RX_PIN])
      periph_in_d.rx = pin_sync[`RX_PIN];
    else
      periph_in_d.rx = 1'b1;
  end

  always_ff @(posedge mclk)
  begin
    if (!rst_b)
      periph_in_q <= '1;
    else
      periph_in_q <= periph_in_d;
  end

  assign periph_in = periph_in_q;

  // Checks over the whole port
  logic [7:0] free_v;
  logic [7:0] low_free;
  logic [7:0] cex_v;

  assign free_v = ~claimed_d;
  assign low_free = free_v & (~free_v + 8'h01);

  always_comb
  begin
    cex_v = 8'h00;
    for (int p = 0; p < PINS; p++)
      cex_v[p] = (func_d[p] >= crossbar_pkg::FN_COUNTER_MODULE_OUT0) && (func_d[p] <= crossbar_pkg::FN_CEX2);
  end

  sequence sel_write;
    reg_wr && (reg_addr == `ADDR_PERIPH_SEL);
  endsequence

  sequence xbar_write_on;
    reg_wr && (reg_addr == `ADDR_GLOBAL_CTRL) && reg_wdata[`BIT_CROSSBAR_ON];
  endsequence

  smb_pair_a: assert property (@(posedge mclk) disable iff (!rst_b)
    $countones(is_sda_v) == $countones(is_scl_v))
    else $error("bus data and clock not paired");

  tx_fixed_a: assert property (@(posedge mclk) disable iff (!rst_b)
    sel_q[`BIT_TX_ROUTE] && xbar_on && in_type_q[`TX_PIN] && drv_type_q[`TX_PIN]
    |=> pin_oe[`TX_PIN] && (pin_out[`TX_PIN] == $past(periph_out.tx)))
    else $error("transmit not on its fixed pin");

  rx_fixed_a: assert property (@(posedge mclk) disable iff (!rst_b)
    sel_q[`BIT_RX_ROUTE] && xbar_on && in_type_q[`RX_PIN]
    |=> periph_in.rx == $past(pin_sync[`RX_PIN]))
    else $error("receive not taken from its fixed pin");

  contiguous_a: assert property (@(posedge mclk) disable iff (!rst_b)
    (placed_d & ~((low_free - 8'h01) | low_free)) == 8'h00)
    else $error("signal placed above a free pin");

  cex_count_a: assert property (@(posedge mclk) disable iff (!rst_b)
    $countones(cex_v) <= sel_q[`BIT_CEX_HI:`BIT_CEX_LO])
    else $error("too many counter outputs placed");

  xbar_enable_a: assert property (@(posedge mclk) disable iff (!rst_b)
    xbar_write_on |=> xbar_on)
    else $error("crossbar did not switch on");

  xbar_off_a: assert property (@(posedge mclk) disable iff (!rst_b)
    !xbar_on |=> pin_oe == 8'h00)
    else $error("pin driven while crossbar off");

  reset_input_a: assert property (@(posedge mclk)
    !rst_b |=> in_type_q == `RST_INPUT_TYPE && pin_rx_en == 8'hFF)
    else $error("pins not digital after reset");

  sel_effect_a: assert property (@(posedge mclk) disable iff (!rst_b)
    sel_write |=> sel_q == $past(reg_wdata))
    else $error("routing write not applied next cycle");
endmodule

// >>> testbench/periph_pad_model.sv
// Partner model of the on-chip peripherals and the external pads
`timescale 1ns/1ps
module periph_pad_model
(
  input wire logic mclk,
  input wire crossbar_pkg::periph_out_t level_req,
  input wire logic [7:0] ext_en,
  input wire logic [7:0] ext_val,
  input wire logic [7:0] pin_out,
  input wire logic [7:0] pin_oe,
  input wire logic [7:0] pin_pullup_en,
  output crossbar_pkg::periph_out_t periph_out,
  output logic [7:0] pin_in
);
  logic [7:0] last_q = 8'h00;

  // Peripherals change their levels just after the edge, same clock
  always_ff @(posedge mclk)
  begin
    periph_out <= level_req;
    last_q <= pin_in;
  end

  // Pad level: own driver, then outside source, then pull-up
  // A floating pad flips every cycle so a stale value never looks valid
  always_comb
  begin
    for (int i = 0; i < 8; i++)
    begin
      if (pin_oe[i])
        pin_in[i] = pin_out[i];
      else if (ext_en[i])
        pin_in[i] = ext_val[i];
      else if (pin_pullup_en[i])
        pin_in[i] = 1'b1;
      else
        pin_in[i] = ~last_q[i];
    end
  end
endmodule

// >>> testbench/tb_port_crossbar_pin_assign.sv
// Self-checking testbench for the port crossbar
`timescale 1ns/1ps
`include "crossbar_defines.svh"
module tb_port_crossbar_pin_assign;
  logic mclk = 1'b0;
  logic rst_b = 1'b0;
  logic [7:0] reg_addr = 8'h00;
  logic [7:0] reg_wdata = 8'h00;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic [7:0] reg_rdata;
  crossbar_pkg::periph_out_t level_req = '1;
  crossbar_pkg::periph_out_t periph_out;
  crossbar_pkg::periph_in_t periph_in;
  logic [7:0] gpio_latch = 8'h00;
  logic [7:0] ext_en = 8'h00;
  logic [7:0] ext_val = 8'h00;
  logic [7:0] pin_in, pin_out, pin_oe, pin_pullup_en, pin_rx_en, pin_level;
  int failures = 0;
  int check_count = 0;
  logic [7:0] rv;

  always #5 mclk = ~mclk;

  port_crossbar_pin_assign dut (.mclk(mclk), .rst_b(rst_b), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .periph_out(periph_out), .periph_in(periph_in), .gpio_latch(gpio_latch),
    .pin_in(pin_in), .pin_out(pin_out), .pin_oe(pin_oe), .pin_pullup_en(pin_pullup_en),
    .pin_rx_en(pin_rx_en), .pin_level(pin_level));

  periph_pad_model partner (.mclk(mclk), .level_req(level_req), .ext_en(ext_en),
    .ext_val(ext_val), .pin_out(pin_out), .pin_oe(pin_oe),
    .pin_pullup_en(pin_pullup_en), .periph_out(periph_out), .pin_in(pin_in));

  task automatic end_of_test();
    $display("checks %0d mismatches %0d", check_count, failures);
    if (failures == 0 && check_count > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask

  task automatic chk(input string what, input logic [7:0] seen, input logic [7:0] exp);
    check_count++;
    if (seen !== exp)
    begin
      failures++;
      $display("wrong value %s expected %h seen %h", what, exp, seen);
    end
  endtask

  // One-cycle write strobe, released at the next edge
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge mclk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge mclk);
    reg_wr <= 1'b0;
  endtask

  // Read data stand only in the cycle after the strobe
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge mclk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge mclk);
    reg_rd <= 1'b0;
    #1 d = reg_rdata;
  endtask

  // Configuration in the safe order, then time for pins and synchronisers
  task automatic cfg(input logic [7:0] inp, drv, skp, sel, glb);
    wr(`ADDR_INPUT_TYPE, inp);
    wr(`ADDR_DRIVE_TYPE, drv);
    wr(`ADDR_SKIP_MASK, skp);
    wr(`ADDR_PERIPH_SEL, sel);
    wr(`ADDR_GLOBAL_CTRL, glb);
    repeat (6) @(posedge mclk);
    #1;
  endtask

  task automatic t_reset();
    logic [7:0] addrs [7] = '{8'hE1, 8'hE2, 8'hE3, 8'hF1, 8'hF4, 8'hE4, 8'h10};
    logic [7:0] vals [7] = '{8'h00, 8'h00, 8'h00, 8'hFF, 8'h00, 8'h00, 8'h00};
    chk("oe", pin_oe, 8'h00);
    chk("rx_en", pin_rx_en, 8'hFF);
    chk("periph_in", {5'h00, periph_in}, 8'h07);
    for (int i = 0; i < 7; i++)
    begin
      rd(addrs[i], rv);
      chk("reset reg", rv, vals[i]);
    end
    $display("reset test done");
  endtask

  task automatic t_off();
    cfg(8'hFF, 8'hFF, 8'hFF, 8'h3F, 8'h3F);
    chk("oe off", pin_oe, 8'h00);
    chk("periph_in off", {5'h00, periph_in}, 8'h07);
    rd(`ADDR_SKIP_MASK, rv);
    chk("skip", rv, 8'h7F);
    rd(`ADDR_GLOBAL_CTRL, rv);
    chk("global", rv, 8'h00);
    $display("disabled test done");
  endtask

  task automatic t_twowire();
    level_req.sda <= 1'b0;
    level_req.scl <= 1'b1;
    cfg(8'hFF, 8'hFF, 8'h00, 8'h04, 8'h40);
    chk("bus oe", {6'h00, pin_oe[1:0]}, 8'h01);
    chk("bus out", {6'h00, pin_out[1:0]}, 8'h00);
    // Data pin pulled low reads back low, released clock pin reads high
    chk("bus in", {5'h00, periph_in}, 8'h05);
    rd(`ADDR_PIN_CLAIMED, rv);
    chk("bus claimed", rv, 8'h03);
    level_req <= '1;
    $display("two-wire test done");
  endtask

  task automatic t_serial();
    ext_en <= 8'h20;
    ext_val <= 8'h00;
    for (int s = 1; s < 4; s++)
    begin
      cfg(8'hFF, 8'hFF, 8'h30, s[7:0], 8'h40);
      rd(`ADDR_PIN_CLAIMED, rv);
      chk("serial claimed", rv, {2'b00, s[1:0], 4'h0});
      chk("tx pin", {7'h00, pin_out[4]}, {7'h00, s[0]});
      // Without receive, pin 5 is a push-pull port pin driving its latch
      chk("rx oe", {7'h00, pin_oe[5]}, {7'h00, ~s[1]});
      chk("rx in", {7'h00, periph_in.rx}, {7'h00, ~s[1]});
    end
    ext_en <= 8'h00;
    $display("serial test done");
  endtask

  task automatic t_priority();
    logic [7:0] sel [4] = '{8'h00, 8'h08, 8'h10, 8'h20};
    logic [7:0] claim [4] = '{8'h00, 8'h01, 8'h01, 8'h01};
    logic [7:0] oe0 [4] = '{8'h01, 8'h01, 8'h00, 8'h01};
    for (int f = 0; f < 4; f++)
    begin
      cfg(8'hFF, 8'hFF, 8'h00, {f[1:0], 6'h00}, 8'h40);
      rd(`ADDR_PIN_CLAIMED, rv);
      chk("counter claimed", rv, 8'((1 << f) - 1));
    end
    level_req <= 9'h1FF ^ 9'h018;
    // Open-drain pin 0 pulls low exactly when its routed level is low
    for (int i = 0; i < 4; i++)
    begin
      cfg(8'hFF, 8'h00, 8'h00, sel[i], 8'h40);
      rd(`ADDR_PIN_CLAIMED, rv);
      chk("single claimed", rv, claim[i]);
      chk("pin0 oe", {7'h00, pin_oe[0]}, oe0[i]);
      chk("pin0 out", {7'h00, pin_out[0]}, 8'h00);
    end
    level_req <= 9'h1C0 | 9'h010;
    cfg(8'hFF, 8'hFF, 8'h44, 8'h3C, 8'h40);
    rd(`ADDR_PIN_CLAIMED, rv);
    chk("skip claimed", rv, 8'h3B);
    chk("skip out", pin_out, 8'h10);
    chk("skip oe", pin_oe, 8'hFC);
    level_req <= '1;
    $display("priority test done");
  endtask

  task automatic t_pullup();
    gpio_latch <= 8'h0F;
    cfg(8'hBF, 8'h00, 8'h40, 8'h00, 8'h40);
    chk("pull od", pin_pullup_en, 8'h0F);
    chk("od oe", pin_oe, 8'hB0);
    chk("rx_en", pin_rx_en, 8'hBF);
    chk("level", pin_level, 8'h4F);
    cfg(8'hBF, 8'h00, 8'h40, 8'h00, 8'hC0);
    chk("pull off", pin_pullup_en, 8'h00);
    cfg(8'hFF, 8'hFF, 8'h00, 8'h00, 8'h40);
    chk("pull pp", pin_pullup_en, 8'h00);
    gpio_latch <= 8'h00;
    $display("pull-up test done");
  endtask

  initial
  begin
    repeat (8) @(posedge mclk);
    rst_b <= 1'b1;
    repeat (2) @(posedge mclk);
    #1;
    t_reset();
    t_off();
    t_twowire();
    t_serial();
    t_priority();
    t_pullup();
    end_of_test();
  end

  // Watchdog well past the expected run of a few hundred cycles
  initial
  begin
    #200000;
    failures++;
    end_of_test();
  end
endmodule
